// ### rtl/mef_pkg.sv
package mef_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_FLAGS_FIRST = 16'he502;
  localparam logic [15:0] IDX_FLAGS_SECOND = 16'he503;
  localparam logic [15:0] IDX_ENABLE_FIRST = 16'he50a;
  localparam logic [15:0] IDX_ENABLE_SECOND = 16'he50b;
  localparam logic [15:0] IDX_CLEAR_FIRST = 16'he520;
  localparam logic [15:0] IDX_CLEAR_SECOND = 16'he521;
  localparam logic [15:0] IDX_NOLOAD_PHASE = 16'he608;
  localparam logic [15:0] IDX_PULSE_MODE = 16'he610;
  localparam logic [15:0] IDX_POWER_SIGN = 16'he617;
  localparam logic [15:0] IDX_ACCUM_MODE = 16'he701;

  // first flag register bit positions
  localparam int FB_RCSIGN = 12;
  localparam int FB_SUM2 = 13;
  localparam int FB_PULSE1 = 14;
  localparam int FB_PULSE2 = 15;
  localparam int FB_PULSE3 = 16;
  localparam int FB_DONE = 17;
  localparam int FB_SUM3 = 18;
  localparam int FB_LO = 12;
  localparam int FB_HI = 18;
  // second flag register bit positions
  localparam int SB_TOTAL_NOLOAD_FLAG = 0;
  localparam int SB_FUNDAMENTAL_NOLOAD_FLAG = 1;
  localparam int SB_APPARENT_NOLOAD_FLAG = 2;
  localparam int SB_MVZC = 3;
  localparam int SB_MIZC = 6;
  localparam int SB_VZC = 9;
  localparam int SB_HI = 11;

  // pulse output mode fields
  localparam int PM_SEL1 = 0;
  localparam int PM_SEL2 = 3;
  localparam int PM_SEL3 = 6;
  localparam int PM_DIS1 = 9;
  localparam int PM_DIS2 = 10;
  localparam int PM_DIS3 = 11;
  localparam int PM_W = 12;
  localparam logic [PM_W-1:0] PM_RESET = 12'h000;
  // accumulation mode: reactive sign source select
  localparam int AM_RSEL = 7;
  localparam int AM_W = 8;
  // sign register positions
  localparam int SG_RC = 6;
  localparam int SG_SUM2 = 7;
  localparam int SG_SUM3 = 8;
  // noload phase register fields
  localparam int NP_TOT = 0;
  localparam int NP_FUND = 3;
  localparam int NP_APP = 6;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [2:0] PIN_IDLE = 3'h7;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // event sources from the measurement datapath
  typedef struct packed {
    logic rc_sign_total;
    logic rc_sign_fund;
    logic sum2_sign;
    logic sum3_sign;
    logic [2:0] pulse_raw;
    logic compute_cycle_done;
    logic [2:0] total_noload_phases;
    logic [2:0] fundamental_noload_phases;
    logic [2:0] apparent_noload_phases;
    logic [2:0] missing_vzc;
    logic [2:0] missing_izc;
    logic [2:0] volt_crossing;
  } mef_evt_type;

  // pulse output controls
  typedef struct packed {
    logic [2:0] pulse_pin;
    logic [2:0] pulse_one_power_select;
    logic [2:0] pulse_two_power_select;
    logic [2:0] pulse_three_power_select;
  } mef_pulse_type;

endpackage : mef_pkg

// ### rtl/mef_status.sv
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module mef_status
  import mef_pkg::*;
#(
  parameter bit HAS_REACTIVE = 1'b1,
  parameter bit HAS_FUNDAMENTAL = 1'b1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // datapath events
  input wire mef_evt_type evt,
  // pulse outputs and interrupt
  output mef_pulse_type pulse,
  output logic irq
);

  function automatic logic [31:0] byte_addr(input logic [15:0] idx);
    byte_addr = {14'h0000, idx, 2'h0};
  endfunction : byte_addr

  function automatic logic [31:0] apply_flags(input logic [31:0] cur,
      input logic [31:0] set, input logic [31:0] clr);
    apply_flags = (cur & ~clr) | set;
  endfunction : apply_flags

  // edge helpers shared by the event decode
  function automatic logic changed(input logic prev, input logic now);
    changed = prev != now;
  endfunction : changed

  function automatic logic fell(input logic prev, input logic now);
    fell = prev && !now;
  endfunction : fell

  function automatic logic any_rise(input logic [2:0] now,
      input logic [2:0] prev);
    any_rise = |(now & ~prev);
  endfunction : any_rise

  function automatic logic reg_hit(input logic [31:0] addr,
      input logic [15:0] idx);
    reg_hit = addr == byte_addr(idx);
  endfunction : reg_hit

  logic [31:0] flags_first_ff;
  logic [31:0] flags_second_ff;
  logic [31:0] nxt_flags_first;
  logic [31:0] nxt_flags_second;
  logic [31:0] enable_first_ff;
  logic [31:0] enable_second_ff;
  logic [PM_W-1:0] pulse_mode_ff;
  logic [AM_W-1:0] accum_mode_ff;
  logic rc_sign_ff;
  logic sum2_sign_ff;
  logic sum3_sign_ff;
  logic [2:0] pulse_prev_ff;
  logic [2:0] tot_nl_ff;
  logic [2:0] fund_nl_ff;
  logic [2:0] app_nl_ff;
  logic wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic [31:0] set_first;
  logic [31:0] set_second;
  logic [31:0] clr_first;
  logic [31:0] clr_second;
  logic rc_sign_now;
  logic [2:0] fund_nl_now;
  logic [31:0] power_sign_word;
  logic [31:0] noload_word;
  logic addr_phase;
  logic wr_take;
  logic nxt_irq;
  logic hit_en_first;
  logic hit_en_second;
  logic hit_mode;
  logic hit_accum;
  logic hit_clr_first;
  logic hit_clr_second;
  logic [31:0] rd_word;

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign addr_phase = hsel && hready && htrans == HTRANS_NONSEQ;
  // only whole-word writes are taken
  assign wr_take = addr_phase && hwrite && hsize == HSIZE_WORD;

  // write target decode in the data phase
  assign hit_en_first = wr_pend_ff && reg_hit(wr_addr_ff, IDX_ENABLE_FIRST);
  assign hit_en_second = wr_pend_ff && reg_hit(wr_addr_ff, IDX_ENABLE_SECOND);
  assign hit_mode = wr_pend_ff && reg_hit(wr_addr_ff, IDX_PULSE_MODE);
  assign hit_accum = wr_pend_ff && reg_hit(wr_addr_ff, IDX_ACCUM_MODE);
  assign hit_clr_first = wr_pend_ff && reg_hit(wr_addr_ff, IDX_CLEAR_FIRST);
  assign hit_clr_second = wr_pend_ff && reg_hit(wr_addr_ff, IDX_CLEAR_SECOND);

  // reactive sign source, variant gating
  assign rc_sign_now = HAS_REACTIVE && (accum_mode_ff[AM_RSEL] ?
      evt.rc_sign_fund : evt.rc_sign_total);
  assign fund_nl_now = HAS_FUNDAMENTAL ?
      evt.fundamental_noload_phases : 3'h0;

  // previous sign levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_sign_ff <= 1'b0;
    end else begin
      rc_sign_ff <= rc_sign_now;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum2_sign_ff <= 1'b0;
    end else begin
      sum2_sign_ff <= evt.sum2_sign;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sum3_sign_ff <= 1'b0;
    end else begin
      sum3_sign_ff <= evt.sum3_sign;
    end
  end

  // previous pulse levels, idle high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_prev_ff <= PIN_IDLE;
    end else begin
      pulse_prev_ff <= evt.pulse_raw;
    end
  end

  // previous no-load phase sets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tot_nl_ff <= 3'h0;
    end else begin
      tot_nl_ff <= evt.total_noload_phases;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fund_nl_ff <= 3'h0;
    end else begin
      fund_nl_ff <= fund_nl_now;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      app_nl_ff <= 3'h0;
    end else begin
      app_nl_ff <= evt.apparent_noload_phases;
    end
  end

  // event set vectors
  always_comb begin
    set_first = WORD_ZERO;
    set_first[FB_RCSIGN] = changed(rc_sign_ff, rc_sign_now);
    set_first[FB_SUM2] = changed(sum2_sign_ff, evt.sum2_sign);
    // raw pulse is sampled ahead of the disable gate
    set_first[FB_PULSE1] = fell(pulse_prev_ff[0], evt.pulse_raw[0]);
    set_first[FB_PULSE2] = fell(pulse_prev_ff[1], evt.pulse_raw[1]);
    set_first[FB_PULSE3] = fell(pulse_prev_ff[2], evt.pulse_raw[2]);
    set_first[FB_DONE] = evt.compute_cycle_done;
    set_first[FB_SUM3] = changed(sum3_sign_ff, evt.sum3_sign);
  end

  always_comb begin
    set_second = WORD_ZERO;
    set_second[SB_TOTAL_NOLOAD_FLAG] =
        any_rise(evt.total_noload_phases, tot_nl_ff);
    set_second[SB_FUNDAMENTAL_NOLOAD_FLAG] = any_rise(fund_nl_now, fund_nl_ff);
    set_second[SB_APPARENT_NOLOAD_FLAG] =
        any_rise(evt.apparent_noload_phases, app_nl_ff);
    set_second[SB_MVZC +: 3] = evt.missing_vzc;
    set_second[SB_MIZC +: 3] = evt.missing_izc;
    set_second[SB_VZC +: 3] = evt.volt_crossing;
  end

  // write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= wr_take;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_ff <= WORD_ZERO;
    end else if (addr_phase) begin
      wr_addr_ff <= haddr;
    end
  end

  // write-one-to-clear strobes
  always_comb begin
    clr_first = WORD_ZERO;
    if (hit_clr_first) begin
      clr_first = hwdata;
    end
  end

  always_comb begin
    clr_second = WORD_ZERO;
    if (hit_clr_second) begin
      clr_second = hwdata;
    end
  end

  // sticky flags, set wins over clear
  assign nxt_flags_first = apply_flags(flags_first_ff, set_first,
      clr_first);
  assign nxt_flags_second = apply_flags(flags_second_ff, set_second,
      clr_second);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_first_ff <= WORD_ZERO;
    end else begin
      flags_first_ff <= nxt_flags_first;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_second_ff <= WORD_ZERO;
    end else begin
      flags_second_ff <= nxt_flags_second;
    end
  end

  // software-written control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_first_ff <= WORD_ZERO;
    end else if (hit_en_first) begin
      enable_first_ff <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_second_ff <= WORD_ZERO;
    end else if (hit_en_second) begin
      enable_second_ff <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_mode_ff <= PM_RESET;
    end else if (hit_mode) begin
      pulse_mode_ff <= hwdata[PM_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accum_mode_ff <= '0;
    end else if (hit_accum) begin
      accum_mode_ff <= hwdata[AM_W-1:0];
    end
  end

  // interrupt level
  assign nxt_irq = |(nxt_flags_first & enable_first_ff) ||
      |(nxt_flags_second & enable_second_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= nxt_irq;
    end
  end

  // pulse pins idle high when disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse <= '{pulse_pin: PIN_IDLE, default: 3'h0};
    end else begin
      pulse.pulse_pin[0] <= evt.pulse_raw[0] | pulse_mode_ff[PM_DIS1];
      pulse.pulse_pin[1] <= evt.pulse_raw[1] | pulse_mode_ff[PM_DIS2];
      pulse.pulse_pin[2] <= evt.pulse_raw[2] | pulse_mode_ff[PM_DIS3];
      pulse.pulse_one_power_select <= pulse_mode_ff[PM_SEL1 +: 3];
      pulse.pulse_two_power_select <= pulse_mode_ff[PM_SEL2 +: 3];
      pulse.pulse_three_power_select <= pulse_mode_ff[PM_SEL3 +: 3];
    end
  end

  // readable state words
  always_comb begin
    power_sign_word = WORD_ZERO;
    power_sign_word[SG_RC] = rc_sign_ff;
    power_sign_word[SG_SUM2] = sum2_sign_ff;
    power_sign_word[SG_SUM3] = sum3_sign_ff;
  end

  always_comb begin
    noload_word = WORD_ZERO;
    noload_word[NP_TOT +: 3] = tot_nl_ff;
    noload_word[NP_FUND +: 3] = fund_nl_ff;
    noload_word[NP_APP +: 3] = app_nl_ff;
  end

  // read decode in address phase, data registered for data phase
  always_comb begin
    rd_word = WORD_ZERO;
    if (haddr == byte_addr(IDX_FLAGS_FIRST)) begin
      rd_word[FB_HI:FB_LO] = flags_first_ff[FB_HI:FB_LO];
    end else if (haddr == byte_addr(IDX_FLAGS_SECOND)) begin
      rd_word[SB_HI:0] = flags_second_ff[SB_HI:0];
    end else if (haddr == byte_addr(IDX_ENABLE_FIRST)) begin
      rd_word = enable_first_ff;
    end else if (haddr == byte_addr(IDX_ENABLE_SECOND)) begin
      rd_word = enable_second_ff;
    end else if (haddr == byte_addr(IDX_PULSE_MODE)) begin
      rd_word[PM_W-1:0] = pulse_mode_ff;
    end else if (haddr == byte_addr(IDX_ACCUM_MODE)) begin
      rd_word[AM_W-1:0] = accum_mode_ff;
    end else if (haddr == byte_addr(IDX_POWER_SIGN)) begin
      rd_word = power_sign_word;
    end else if (haddr == byte_addr(IDX_NOLOAD_PHASE)) begin
      rd_word = noload_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= WORD_ZERO;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_word;
    end
  end

endmodule : mef_status

// ### verif/mef_status_chk.sv
`timescale 1ns/1ps
module mef_status_chk
  import mef_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // events and outputs
  input wire mef_evt_type evt,
  input wire mef_pulse_type pulse,
  input wire logic irq
);
  logic wa;
  logic ra;
  assign wa = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
  assign ra = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bus_okay: assert property (
    ra || wa |=> hreadyout && hresp == HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  chk_pin_follow: assert property (
    (~pulse.pulse_pin & $past(evt.pulse_raw)) == 3'h0)
    else $error("pulse pin low without a raw pulse");
  chk_rdata_hold: assert property (!ra |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_irq_hold: assert property (
    irq && !wa && !$past(wa) |=> irq)
    else $error("interrupt dropped without a write");
  chk_irq_quiet: assert property (
    !irq && !wa && !$past(wa) && !$past(wa, 2) && $stable(evt) &&
    !evt.compute_cycle_done && evt.missing_vzc == 3'h0 &&
    evt.missing_izc == 3'h0 && evt.volt_crossing == 3'h0 |=> !irq)
    else $error("interrupt rose without an event");
  chk_sel_hold: assert property (
    !wa && !$past(wa) && !$past(wa, 2) |=>
    $stable({pulse.pulse_one_power_select, pulse.pulse_two_power_select,
    pulse.pulse_three_power_select}))
    else $error("power select moved without a write");
  chk_first_top: assert property (
    ra && haddr == {14'h0, IDX_FLAGS_FIRST, 2'h0} |=>
    hrdata[31:19] == 13'h0)
    else $error("first flags upper bits not zero");
  chk_second_top: assert property (
    ra && haddr == {14'h0, IDX_FLAGS_SECOND, 2'h0} |=>
    hrdata[31:12] == 20'h0)
    else $error("second flags upper bits not zero");
endmodule : mef_status_chk

bind mef_status mef_status_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .evt(evt), .pulse(pulse), .irq(irq));

// ### verif/mef_status_tb.sv
`timescale 1ns/1ps
module mef_status_tb
  import mef_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hready;
  mef_evt_type evt, base, e;
  mef_pulse_type pulse;
  int fail_count, checks, cyc;
  assign hready = hreadyout;
  mef_status DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .evt(evt), .pulse(pulse), .irq(irq));
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [15:0] idx,
      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic fire(input mef_evt_type x);
    evt <= x;
    @(posedge hclk);
    evt <= base;
    @(posedge hclk);
  endtask : fire
  task automatic t_reset;
    bus(1'b0, IDX_FLAGS_FIRST, 32'h0);
    check("first", rd, 32'h0);
    bus(1'b0, IDX_FLAGS_SECOND, 32'h0);
    check("second", rd, 32'h0);
    bus(1'b0, 16'h0000, 32'h0);
    check("unmapped", rd, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
  endtask : t_reset
  task automatic t_first;
    base.rc_sign_total = 1'b1;
    base.sum2_sign = 1'b1;
    base.sum3_sign = 1'b1;
    e = base;
    e.compute_cycle_done = 1'b1;
    fire(e);
    bus(1'b0, IDX_FLAGS_FIRST, 32'h0);
    check("first", rd, 32'h0006_3000);
    bus(1'b0, IDX_POWER_SIGN, 32'h0);
    check("sign", rd, 32'h0000_01c0);
  endtask : t_first
  task automatic t_pulse;
    bus(1'b1, IDX_PULSE_MODE, 32'h0000_0ed1);
    @(posedge hclk);
    #1;
    check("sel", {23'h0, pulse.pulse_three_power_select,
      pulse.pulse_two_power_select, pulse.pulse_one_power_select},
      32'h0000_00d1);
    e = base;
    e.pulse_raw = 3'h0;
    evt <= e;
    @(posedge hclk);
    #1;
    check("pin", {29'h0, pulse.pulse_pin}, 32'h7);
    evt <= base;
    @(posedge hclk);
    bus(1'b0, IDX_FLAGS_FIRST, 32'h0);
    check("first", rd, 32'h0007_f000);
    bus(1'b1, IDX_CLEAR_FIRST, 32'hffff_ffff);
    bus(1'b0, IDX_FLAGS_FIRST, 32'h0);
    check("cleared", rd, 32'h0);
    bus(1'b1, IDX_PULSE_MODE, 32'h0000_0000);
    evt <= e;
    @(posedge hclk);
    #1;
    check("pin low", {29'h0, pulse.pulse_pin}, 32'h0);
    evt <= base;
    @(posedge hclk);
    bus(1'b0, IDX_FLAGS_FIRST, 32'h0);
    check("enabled", rd, 32'h0001_c000);
  endtask : t_pulse
  task automatic t_select;
    bus(1'b1, IDX_ACCUM_MODE, 32'h0000_0080);
    bus(1'b0, IDX_ACCUM_MODE, 32'h0);
    check("accum", rd, 32'h0000_0080);
    bus(1'b1, IDX_CLEAR_FIRST, 32'hffff_ffff);
    base.rc_sign_fund = 1'b1;
    fire(base);
    bus(1'b0, IDX_FLAGS_FIRST, 32'h0);
    check("fund sign", rd, 32'h0000_1000);
    bus(1'b0, IDX_POWER_SIGN, 32'h0);
    check("fund sign reg", rd, 32'h0000_01c0);
  endtask : t_select
  task automatic t_second;
    base.total_noload_phases = 3'h1;
    base.fundamental_noload_phases = 3'h2;
    base.apparent_noload_phases = 3'h4;
    e = base;
    e.missing_vzc = 3'h7;
    e.missing_izc = 3'h7;
    e.volt_crossing = 3'h7;
    fire(e);
    bus(1'b0, IDX_NOLOAD_PHASE, 32'h0);
    check("phases", rd, 32'h0000_0111);
    bus(1'b0, IDX_FLAGS_SECOND, 32'h0);
    check("second", rd, 32'h0000_0fff);
  endtask : t_second
  task automatic t_irq;
    bus(1'b1, IDX_CLEAR_SECOND, 32'hffff_ffff);
    bus(1'b1, IDX_ENABLE_SECOND, 32'h0000_0200);
    bus(1'b0, IDX_ENABLE_SECOND, 32'h0);
    check("enable", rd, 32'h0000_0200);
    e = base;
    e.volt_crossing = 3'h2;
    fire(e);
    #1;
    check("masked", {31'h0, irq}, 32'h0);
    e.volt_crossing = 3'h1;
    fire(e);
    #1;
    check("raised", {31'h0, irq}, 32'h1);
    bus(1'b1, IDX_CLEAR_SECOND, 32'h0000_0200);
    @(posedge hclk);
    #1;
    check("lowered", {31'h0, irq}, 32'h0);
  endtask : t_irq
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test;
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    base = '0;
    base.pulse_raw = 3'h7;
    evt = base;
    fail_count = 0;
    checks = 0;
    cyc = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_first;
    t_pulse;
    t_second;
    t_irq;
    t_select;
    end_of_test;
  end
endmodule : mef_status_tb
